// ==== logic/uart_match_defs.vh ====
// Purpose: Offsets, field positions, reset values and timing counts for the
//          serial address filter and baud/mode control block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Printed offsets 87h, 9Bh, A9h and B9h are not multiples of four, so all offsets are indices.
`ifndef UART_MATCH_DEFS_VH
`define UART_MATCH_DEFS_VH

// Register indices (byte address is four times the index)
`define IDX_POWER_CONTROL      8'h87
`define IDX_BAUD_RATE_CONTROL  8'h9B
`define IDX_SERIAL_CONTROL     8'h98
`define IDX_OWN_ADDRESS        8'hA9
`define IDX_ADDRESS_MASK       8'hB9
`define IDX_RX_STATUS          8'hC0

// Power control fields
`define PC_BAUD_DOUBLE    7
`define PC_ERR_SELECT     6
`define PC_POWER_ON       4
`define PC_GEN_B          3
`define PC_GEN_A          2
`define PC_POWER_DOWN     1
`define PC_SLEEP          0
`define PC_WRITE_MASK     8'hDF
`define PC_RESET_WARM     8'h00

// Baud rate control fields
`define BR_RUN            4
`define BR_TX_SEL         3
`define BR_RX_SEL         2
`define BR_FAST           1
`define BR_M0_SRC         0
`define BR_WRITE_MASK     8'h1F
`define BR_RESET          8'h00

// Serial control fields
`define SC_MODE0          7
`define SC_MODE1          6
`define SC_MULTIPROC      5
`define SC_REN            4
`define SC_TB8            3
`define SC_RB8            2
`define SC_TX_DONE        1
`define SC_RX_DONE        0
`define SC_RESET          8'h00

// Serial modes {mode0, mode1}
`define MODE_SHIFT        2'b00
`define MODE_UART8        2'b01
`define MODE_UART9A       2'b10
`define MODE_UART9B       2'b11

// Mode 0 fixed clock dividers
`define DIV_M0_NORMAL     8'd12
`define DIV_M0_DOUBLE     8'd6

// Rate generator divide ratios (the counter reloads one less) for slow and fast variants
`define BRG_SLOW_DIV      8'd64
`define BRG_FAST_DIV      8'd4

`endif

// ==== logic/uart_addr_match_baud_ctrl.v ====
// Purpose: Receive address filter, baud and mode control, power control
//          registers of an 8-bit controller's asynchronous serial port.
// Assumes: The shift engine sits outside; it reports finished frames.
// Notes:   Registers are reached over APB; no wait states are inserted.
//
// Functional notes
// R1: Address recognition runs whenever the multiprocessor enable bit is set outside mode 0.
// R2: With recognition on, receive flag sets only for frames addressed here.
// R3: In mode 1 recognition needs an address match and a valid stop bit.
// R4: In mode 0 the multiprocessor enable bit has no effect.
// R5: Given address is own address with mask zeros as don't-care.
// R6: Own 0101_0110 with mask 1111_1100 matches any 0101_01XX.
// R7: Baud-double bit doubles the rate in modes 1, 2 and 3.
// R8: Error-select bit routes serial control bit 7 to mode bit or framing error.
// R9: Power-on flag set on cold reset, kept on warm, software may change it.
// R10: Writing one to power-down enters power-down; reset clears it.
// R11: Writing one to idle enters idle; interrupt or reset clears it.
// R12: Power control resets to 00X1_0000, not bit addressable.
// R13: Run bit starts the internal rate generator, clearing stops it.
// R14: Transmit clock select: timers when clear, internal generator when set.
// R15: Receive clock select: timers when clear, internal generator when set.
// R16: Speed bit picks slow generator when clear, fast when set.
// R17: Mode 0 source: oscillator /12 (/6 double speed) or internal generator.
// R18: Baud rate control resets to XXX0_0000, not bit addressable.
// R19: Software never sets reserved bits and ignores their read value.
// R20: Broadcast address is own OR mask, zero bits being don't-care.
// R21: In nine-bit modes only frames with ninth bit one are address frames.
`timescale 1ns/100ps
`include "uart_match_defs.vh"

module uart_addr_match_baud_ctrl (
	input  wire        SYS_CLK,
	input  wire        RESET,
	input  wire        COLD_RESET,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire        RX_FRAME_DONE,
	input  wire [7:0]  RX_DATA,
	input  wire        RX_NINTH_BIT,
	input  wire        RX_STOP_OK,
	input  wire        TX_FRAME_DONE,
	input  wire        INTERRUPT_EVENT,
	input  wire        TIMER_BAUD_TICK,
	input  wire        DOUBLE_SPEED_CORE,
	output reg         RX_BAUD_TICK,
	output reg         TX_BAUD_TICK,
	output reg         SERIAL_DOUBLE_RATE,
	output wire [1:0]  SERIAL_MODE,
	output reg  [7:0]  RX_BUFFER,
	output wire        RX_DONE,
	output reg         POWER_DOWN,
	output reg         SLEEP
);

	// Register state
	reg  [7:0] power_control_q;
	reg  [7:0] baud_rate_control_q;
	reg  [7:0] serial_control_q;
	reg  [7:0] own_address_q;
	reg  [7:0] address_mask_q;
	reg        framing_error_q;
	reg  [7:0] brg_count_q;
	reg  [7:0] m0_count_q;
	reg        cold_seen_q;
	reg        power_on_keep_q;
	reg        accept_ok;

	// Overview of the datapath:
	// - APB decode picks one of six byte-wide registers.
	// - The filter compares each finished frame with the
	//   given and broadcast addresses.
	// - The rate generator and the mode 0 divider feed the
	//   baud tick routing.
	// - Power control holds the doubling, error-select,
	//   power-on, general, power-down and idle bits.
	// The shift engine itself is outside; it only hands
	// over finished frames with their ninth and stop bits.
	//
	// Timing summary:
	// - Register writes land at the access-phase edge.
	// - Accepted frames raise the done flag one edge later.
	// - Tick, doubling and power outputs lag one edge more,
	//   because they come straight from flip-flops.

	wire       apb_write;
	wire       apb_read;
	wire [9:0] reg_index;
	wire       hit_pc;
	wire       hit_br;
	wire       hit_sc;
	wire       hit_own;
	wire       hit_mask;
	wire       hit_stat;
	wire       hit_any;
	wire [1:0] mode;
	wire       multiproc_active;
	wire       nine_bit_mode;
	wire [7:0] given_care;
	wire       given_match;
	wire       bcast_match;
	wire       addr_ok;
	wire       frame_accept;
	wire       rx_done_set;
	wire       brg_run;
	wire       brg_tick;
	wire [7:0] brg_div;
	wire [7:0] m0_div;
	wire       m0_tick;
	wire [7:0] sc_read;
	wire [7:0] power_read;

	// Access strobes; the slave never waits, so an access ends in one phase
	assign apb_write = PSEL & PENABLE & PWRITE;
	assign apb_read  = PSEL & ~PWRITE;
	assign PREADY    = 1'b1;
	assign reg_index = PADDR[11:2];
	assign hit_pc    = (reg_index == {2'b00, `IDX_POWER_CONTROL});
	assign hit_br    = (reg_index == {2'b00, `IDX_BAUD_RATE_CONTROL});
	assign hit_sc    = (reg_index == {2'b00, `IDX_SERIAL_CONTROL});
	assign hit_own   = (reg_index == {2'b00, `IDX_OWN_ADDRESS});
	assign hit_mask  = (reg_index == {2'b00, `IDX_ADDRESS_MASK});
	assign hit_stat  = (reg_index == {2'b00, `IDX_RX_STATUS});
	assign hit_any   = hit_pc | hit_br | hit_sc | hit_own | hit_mask | hit_stat;
	// Unmapped addresses and misaligned offsets answer with an error
	assign PSLVERR   = PSEL & PENABLE & (~hit_any | (PADDR[1:0] != 2'b00));

	// Mode decode and recognition gating
	assign mode             = {serial_control_q[`SC_MODE0], serial_control_q[`SC_MODE1]};
	assign SERIAL_MODE      = mode;
	assign multiproc_active = serial_control_q[`SC_MULTIPROC] &
	                          (mode != `MODE_SHIFT);                   // [R1] [R4]
	assign nine_bit_mode    = mode[1];

	// Given and broadcast address compare; mask zeros are don't-care in the given compare
	assign given_care  = address_mask_q;                               // [R5]
	assign given_match = ((RX_DATA ^ own_address_q) & given_care) == 8'h00; // [R5] [R6]
	// Broadcast: zeros of own OR mask are don't-care, ones must match
	assign bcast_match = ((~RX_DATA) & (own_address_q | address_mask_q)) == 8'h00; // [R20]
	assign addr_ok     = given_match | bcast_match;

	// Frame acceptance per mode
	always @* begin : accept_logic
		reg ok;
		ok = 1'b1;
		if (!multiproc_active) begin
			ok = 1'b1;                                         // [R4]
		end else if (nine_bit_mode) begin
			// Only ninth-bit-one frames are addresses; data frames dropped
			ok = RX_NINTH_BIT & addr_ok;                       // [R2] [R21]
		end else begin
			ok = addr_ok & RX_STOP_OK;                         // [R3]
		end
		accept_ok = ok;
	end

	// A rejected frame still updates the framing error,
	// so software can see line trouble on foreign frames
	assign frame_accept = accept_ok;
	assign rx_done_set  = RX_FRAME_DONE & frame_accept;                // [R2]
	assign RX_DONE      = serial_control_q[`SC_RX_DONE];

	// Bit 7 of serial control reads mode bit or framing error
	assign sc_read = {power_control_q[`PC_ERR_SELECT] ? framing_error_q :
	                  serial_control_q[`SC_MODE0], serial_control_q[6:0]}; // [R8]
	assign power_read = power_control_q;

	// Power control register.
	// Warm reset clears every bit here, including the
	// power-down and idle requests, so the core wakes up.
	// The power-on flag cannot live in this register's reset
	// domain: a warm reset would wipe it. A copy set by cold
	// reset and by software writes is reloaded on the first edge
	// after release of the RESET input.
	// Limitation: a read in the very first cycle after
	// release would still show the flag as zero; the bus
	// master must wait one edge, which APB setup gives it.
	// Power control; cold reset sets power-on flag, warm reset keeps it
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			power_control_q <= `PC_RESET_WARM;                  // [R10] [R11] [R12]
			cold_seen_q     <= 1'b0;
		end else begin
			cold_seen_q <= 1'b1;
			if (apb_write && hit_pc) begin
				power_control_q <= PWDATA[7:0] & `PC_WRITE_MASK;    // [R10] [R11]
			end
			if (!cold_seen_q) begin
				// First edge after release: load flag kept through warm reset
				power_control_q[`PC_POWER_ON] <= power_on_keep_q;   // [R9] [R12]
			end
			if (INTERRUPT_EVENT) begin
				power_control_q[`PC_SLEEP] <= 1'b0;                 // [R11]
			end
		end
	end

	// Power-on flag lives outside the reset domain of the register;
	// only the cold reset input or software changes it
	always @(posedge SYS_CLK or posedge COLD_RESET) begin
		if (COLD_RESET) begin
			power_on_keep_q <= 1'b1;                           // [R9]
		end else if (!RESET && apb_write && hit_pc) begin
			power_on_keep_q <= PWDATA[`PC_POWER_ON];           // [R9]
		end
	end

	// Baud rate control register, own address and mask
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			baud_rate_control_q <= `BR_RESET;                  // [R18]
			own_address_q       <= 8'h00;
			address_mask_q      <= 8'h00;
		end else begin
			if (apb_write && hit_br) begin
				baud_rate_control_q <= PWDATA[7:0] & `BR_WRITE_MASK; // [R18]
			end
			if (apb_write && hit_own) begin
				own_address_q <= PWDATA[7:0];
			end
			if (apb_write && hit_mask) begin
				address_mask_q <= PWDATA[7:0];
			end
		end
	end

	// Serial control register.
	// The done flags are sticky: software clears them by
	// writing zero. If a frame finishes in the same cycle
	// as that write, the hardware set is applied last and
	// wins, so no frame is ever lost to a racing clear.
	// With error-select set, bit 7 writes go to the framing
	// error flag and the mode bit is left untouched.

	// Serial control with sticky done flags; hardware set beats clear
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			serial_control_q <= `SC_RESET;
			framing_error_q  <= 1'b0;
			RX_BUFFER        <= 8'h00;
		end else begin
			if (apb_write && hit_sc) begin
				serial_control_q <= PWDATA[7:0];
				// Error-select set: bit 7 write goes to framing error
				if (power_control_q[`PC_ERR_SELECT]) begin
					serial_control_q[`SC_MODE0] <= serial_control_q[`SC_MODE0]; // [R8]
					framing_error_q <= PWDATA[7];              // [R8]
				end
			end
			if (rx_done_set) begin
				serial_control_q[`SC_RX_DONE] <= 1'b1;         // [R2] [R3]
				serial_control_q[`SC_RB8]     <= RX_NINTH_BIT;
				RX_BUFFER <= RX_DATA;
			end
			if (TX_FRAME_DONE) begin
				serial_control_q[`SC_TX_DONE] <= 1'b1;
			end
			if (RX_FRAME_DONE && !RX_STOP_OK) begin
				framing_error_q <= 1'b1;
			end
		end
	end

	// Rate generator.
	// A down counter reloads from the slow or fast divider.
	// Stopping it forces the count to zero, so the first
	// tick after a restart comes on the next edge; this
	// trades an early tick for a simpler restart path.

	// Internal rate generator; slow or fast reload
	assign brg_run = baud_rate_control_q[`BR_RUN];                     // [R13]
	assign brg_div = baud_rate_control_q[`BR_FAST] ? `BRG_FAST_DIV : `BRG_SLOW_DIV; // [R16]
	assign brg_tick = brg_run && (brg_count_q == 8'h00);
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			brg_count_q <= 8'h00;
		end else if (!brg_run) begin
			brg_count_q <= 8'h00;                              // [R13]
		end else if (brg_count_q == 8'h00) begin
			brg_count_q <= brg_div - 8'h01;                    // [R16]
		end else begin
			brg_count_q <= brg_count_q - 8'h01;
		end
	end

	// Mode 0 fixed divider: /12, or /6 in double-speed core mode
	assign m0_div  = DOUBLE_SPEED_CORE ? `DIV_M0_DOUBLE : `DIV_M0_NORMAL; // [R17]
	assign m0_tick = (m0_count_q == 8'h00);
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			m0_count_q <= 8'h00;
		end else if (m0_count_q == 8'h00) begin
			m0_count_q <= m0_div - 8'h01;
		end else begin
			m0_count_q <= m0_count_q - 8'h01;
		end
	end

	// Baud clock routing and registered outputs
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			RX_BAUD_TICK       <= 1'b0;
			TX_BAUD_TICK       <= 1'b0;
			SERIAL_DOUBLE_RATE <= 1'b0;
			POWER_DOWN         <= 1'b0;
			SLEEP              <= 1'b0;
		end else begin
			if (mode == `MODE_SHIFT) begin
				RX_BAUD_TICK <= baud_rate_control_q[`BR_M0_SRC] ? brg_tick : m0_tick; // [R17]
				TX_BAUD_TICK <= baud_rate_control_q[`BR_M0_SRC] ? brg_tick : m0_tick; // [R17]
			end else begin
				RX_BAUD_TICK <= baud_rate_control_q[`BR_RX_SEL] ? brg_tick
				                                                 : TIMER_BAUD_TICK; // [R15]
				TX_BAUD_TICK <= baud_rate_control_q[`BR_TX_SEL] ? brg_tick
				                                                 : TIMER_BAUD_TICK; // [R14]
			end
			// Doubling is meaningless in the shift mode
			SERIAL_DOUBLE_RATE <= power_control_q[`PC_BAUD_DOUBLE] &
			                      (mode != `MODE_SHIFT);          // [R7]
			POWER_DOWN <= power_control_q[`PC_POWER_DOWN];          // [R10]
			SLEEP      <= power_control_q[`PC_SLEEP];               // [R11]
		end
	end

	// Read path.
	// Reserved bits read as zero here, though software may
	// not rely on that. Unmapped reads return zero and are
	// flagged with an error response in the access phase.

	// Read mux; reserved bits and upper bits read as zero
	always @* begin
		PRDATA = 32'h00000000;
		if (apb_read) begin
			if (hit_pc) begin
				PRDATA[7:0] = power_read;
			end else if (hit_br) begin
				PRDATA[7:0] = baud_rate_control_q;
			end else if (hit_sc) begin
				PRDATA[7:0] = sc_read;
			end else if (hit_own) begin
				PRDATA[7:0] = own_address_q;
			end else if (hit_mask) begin
				PRDATA[7:0] = address_mask_q;
			end else if (hit_stat) begin
				PRDATA[7:0] = {7'h00, framing_error_q};
			end else begin
				PRDATA = 32'h00000000;
			end
		end
	end

endmodule // uart_addr_match_baud_ctrl

// ==== testbench/uart_match_assertions.sv ====
// Purpose: Port-level checks on the serial filter and control block.
// Assumes: Register indices come from the shared header.
// Notes:   The multiprocessor bit is mirrored from bus writes.
`timescale 1ns/100ps
`include "uart_match_defs.vh"
module uart_match_checker (
	input wire        SYS_CLK,
	input wire        RESET,
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire        PSLVERR,
	input wire        RX_FRAME_DONE,
	input wire        RX_NINTH_BIT,
	input wire        RX_STOP_OK,
	input wire        INTERRUPT_EVENT,
	input wire        SERIAL_DOUBLE_RATE,
	input wire [1:0]  SERIAL_MODE,
	input wire        RX_DONE,
	input wire        POWER_DOWN,
	input wire        SLEEP
);
	reg        mp_q;
	wire       acc   = PSEL & PENABLE;
	wire [9:0] ix    = PADDR[11:2];
	wire       sc_wr = acc & PWRITE & (ix == `IDX_SERIAL_CONTROL) & (PADDR[1:0] == 2'h0);
	wire       pc_wr = acc & PWRITE & (ix == `IDX_POWER_CONTROL) & (PADDR[1:0] == 2'h0);
	// Misaligned offsets count as unmapped
	wire       mapped = (PADDR[1:0] == 2'h0) && (ix == `IDX_POWER_CONTROL
		|| ix == `IDX_BAUD_RATE_CONTROL || ix == `IDX_SERIAL_CONTROL
		|| ix == `IDX_OWN_ADDRESS || ix == `IDX_ADDRESS_MASK || ix == `IDX_RX_STATUS);
	// Mirror of the enable bit; only the bus can change it
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			mp_q <= 1'b0;
		else if (sc_wr)
			mp_q <= PWDATA[`SC_MULTIPROC];
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	quiet_reset_a: assert property (disable iff (1'b0) RESET |-> !RX_DONE && !POWER_DOWN && !SLEEP)
		else $error("outputs active during reset");
	mode0_accept_a: assert property (RX_FRAME_DONE && SERIAL_MODE == `MODE_SHIFT |=> RX_DONE)
		else $error("mode 0 frame not flagged");
	ninth_filter_a: assert property (RX_FRAME_DONE && mp_q && SERIAL_MODE[1] && !RX_NINTH_BIT
		&& !RX_DONE && !sc_wr |=> !RX_DONE) else $error("data frame flagged");
	stop_filter_a: assert property (RX_FRAME_DONE && mp_q && SERIAL_MODE == `MODE_UART8
		&& !RX_STOP_OK && !RX_DONE && !sc_wr |=> !RX_DONE) else $error("bad stop flagged");
	bus_refuse_a: assert property (acc |-> PSLVERR == !mapped)
		else $error("error response wrong");
	read_upper_a: assert property (PSEL && !PWRITE |-> PRDATA[31:8] == 24'h000000)
		else $error("upper read bits set");
	sleep_wake_a: assert property (INTERRUPT_EVENT && !pc_wr |-> ##2 !SLEEP)
		else $error("idle kept after interrupt");
	pdown_enter_a: assert property (pc_wr && PWDATA[`PC_POWER_DOWN] |-> ##2 POWER_DOWN)
		else $error("power-down not entered");
	double_mode_a: assert property (SERIAL_MODE == `MODE_SHIFT && $past(SERIAL_MODE) == `MODE_SHIFT
		|-> !SERIAL_DOUBLE_RATE) else $error("doubling in mode 0");
endmodule // uart_match_checker

bind uart_addr_match_baud_ctrl uart_match_checker u_chk (
	.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
	.RX_FRAME_DONE(RX_FRAME_DONE), .RX_NINTH_BIT(RX_NINTH_BIT), .RX_STOP_OK(RX_STOP_OK),
	.INTERRUPT_EVENT(INTERRUPT_EVENT), .SERIAL_DOUBLE_RATE(SERIAL_DOUBLE_RATE),
	.SERIAL_MODE(SERIAL_MODE), .RX_DONE(RX_DONE), .POWER_DOWN(POWER_DOWN), .SLEEP(SLEEP));

// ==== testbench/serial_node.sv ====
// Purpose: Far-side node whose frames reach the receive filter.
// Assumes: The shift engine hands over one frame per pulse.
// Notes:   Fields are inverted outside the pulse so stale values never match.
`timescale 1ns/100ps
module serial_node (
	input  wire       clk,
	output reg        done = 1'b0,
	output reg  [7:0] data = 8'h00,
	output reg        ninth = 1'b0,
	output reg        stop_ok = 1'b0
);
	// One frame: fields valid only with the pulse
	task send(input [7:0] d, input n, input s);
		begin
			@(posedge clk);
			done <= 1'b1;
			data <= d;
			ninth <= n;
			stop_ok <= s;
			@(posedge clk);
			done <= 1'b0;
			data <= ~d;
			ninth <= ~n;
			stop_ok <= ~s;
		end
	endtask
endmodule // serial_node

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the serial filter and control block.
// Assumes: Zero-wait APB, byte address four times the register index.
// Notes:   Transmit-done input is tied low; it has no checked effect here.
`timescale 1ns/100ps
`include "uart_match_defs.vh"
module testbench;
	localparam [11:0] A_PC  = `IDX_POWER_CONTROL * 12'h004;
	localparam [11:0] A_BR  = `IDX_BAUD_RATE_CONTROL * 12'h004;
	localparam [11:0] A_SC  = `IDX_SERIAL_CONTROL * 12'h004;
	localparam [11:0] A_ST  = `IDX_RX_STATUS * 12'h004;
	reg         SYS_CLK = 1'b0;
	reg         RESET = 1'b1;
	reg         COLD_RESET = 1'b1;
	reg         PSEL = 1'b0;
	reg         PENABLE = 1'b0;
	reg         PWRITE = 1'b0;
	reg  [11:0] PADDR = 12'h000;
	reg  [31:0] PWDATA = 32'h00000000;
	reg         INTERRUPT_EVENT = 1'b0;
	reg         TIMER_BAUD_TICK = 1'b0;
	reg         DOUBLE_SPEED_CORE = 1'b0;
	reg         tmr_en = 1'b0;
	reg  [31:0] rd;
	integer     n_fail = 0;
	integer     n_checks = 0;
	wire [31:0] PRDATA;
	wire [7:0]  RX_DATA, RX_BUFFER;
	wire [1:0]  SERIAL_MODE;
	wire        PREADY, PSLVERR, RX_FRAME_DONE, RX_NINTH_BIT, RX_STOP_OK, RX_BAUD_TICK;
	wire        TX_BAUD_TICK, SERIAL_DOUBLE_RATE, RX_DONE, POWER_DOWN, SLEEP;
	always #5 SYS_CLK = ~SYS_CLK;
	// Timer source pulses every other cycle while enabled
	always @(posedge SYS_CLK) TIMER_BAUD_TICK <= tmr_en & ~TIMER_BAUD_TICK;
	uart_addr_match_baud_ctrl u_uart_addr_match_baud_ctrl (
		.SYS_CLK(SYS_CLK), .RESET(RESET), .COLD_RESET(COLD_RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .RX_FRAME_DONE(RX_FRAME_DONE), .RX_DATA(RX_DATA),
		.RX_NINTH_BIT(RX_NINTH_BIT), .RX_STOP_OK(RX_STOP_OK), .TX_FRAME_DONE(1'b0),
		.INTERRUPT_EVENT(INTERRUPT_EVENT), .TIMER_BAUD_TICK(TIMER_BAUD_TICK),
		.DOUBLE_SPEED_CORE(DOUBLE_SPEED_CORE), .RX_BAUD_TICK(RX_BAUD_TICK),
		.TX_BAUD_TICK(TX_BAUD_TICK), .SERIAL_DOUBLE_RATE(SERIAL_DOUBLE_RATE),
		.SERIAL_MODE(SERIAL_MODE), .RX_BUFFER(RX_BUFFER), .RX_DONE(RX_DONE),
		.POWER_DOWN(POWER_DOWN), .SLEEP(SLEEP));
	serial_node u_serial_node (.clk(SYS_CLK), .done(RX_FRAME_DONE), .data(RX_DATA),
		.ninth(RX_NINTH_BIT), .stop_ok(RX_STOP_OK));
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("[ERR] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task end_sim;
		begin
			if (n_fail == 0 && n_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task apb(input w, input [11:0] a, input [31:0] d);
		integer i;
		begin
			@(posedge SYS_CLK);
			PSEL <= 1'b1;
			PWRITE <= w;
			PADDR <= a;
			PWDATA <= d;
			@(posedge SYS_CLK);
			PENABLE <= 1'b1;
			i = 0;
			do begin
				@(posedge SYS_CLK);
				i = i + 1;
			end while (PREADY !== 1'b1 && i < 20);
			rd = {PRDATA[31:1], PRDATA[0] | 1'b0};
			rd[31] = PSLVERR;
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
			chk("pready", 32'h00000001, {31'h00000000, PREADY});
			if (PREADY !== 1'b1)
				end_sim;
		end
	endtask
	task rdc(input string nm, input [11:0] a, input [31:0] exp, input [31:0] m);
		begin
			apb(1'b0, a, 32'h00000000);
			chk(nm, exp, rd & m);
		end
	endtask
	task ticks(input integer n, input [31:0] e);
		integer i, tx, rx;
		begin
			tx = 0;
			rx = 0;
			repeat (8) @(posedge SYS_CLK);
			for (i = 0; i < n; i = i + 1) begin
				@(posedge SYS_CLK);
				#1;
				tx = tx + TX_BAUD_TICK;
				rx = rx + RX_BAUD_TICK;
			end
			chk("tx ticks", e, tx);
			chk("rx ticks", e, rx);
		end
	endtask
	task rst(input cold);
		begin
			@(posedge SYS_CLK);
			RESET <= 1'b1;
			COLD_RESET <= cold;
			@(posedge SYS_CLK);
			RESET <= 1'b0;
			COLD_RESET <= 1'b0;
			repeat (2) @(posedge SYS_CLK);
		end
	endtask
	task frame(input [7:0] sc, input [7:0] d, input n, input s, input ok);
		begin
			apb(1'b1, A_SC, {24'h000000, sc});
			u_serial_node.send(d, n, s);
			@(posedge SYS_CLK);
			#1;
			chk("rx done", {31'h00000000, ok}, {31'h00000000, RX_DONE});
			if (ok)
				chk("rx buffer", {24'h000000, d}, {24'h000000, RX_BUFFER});
		end
	endtask
	task t_reset;
		begin
			rdc("power reset", A_PC, 32'h00000010, 32'h000000DF);
			rdc("baud reset", A_BR, 32'h00000000, 32'h0000001F);
			rdc("unmapped", 12'h004, 32'h80000000, 32'h80000000);
			rdc("misaligned", A_PC + 12'h001, 32'h80000000, 32'h80000000);
		end
	endtask
	task t_baud;
		begin
			apb(1'b1, A_SC, 32'h00000040);
			apb(1'b1, A_BR, 32'h0000001E);
			ticks(40, 10);
			apb(1'b1, A_BR, 32'h0000001C);
			ticks(128, 2);
			apb(1'b1, A_BR, 32'h0000000E);
			ticks(40, 0);
			tmr_en <= 1'b1;
			apb(1'b1, A_BR, 32'h00000010);
			ticks(40, 20);
			tmr_en <= 1'b0;
			rdc("baud rw", A_BR, 32'h00000010, 32'h0000001F);
			apb(1'b1, A_SC, 32'h00000000);
			ticks(120, 10);
			DOUBLE_SPEED_CORE <= 1'b1;
			ticks(120, 20);
			apb(1'b1, A_BR, 32'h00000013);
			ticks(40, 10);
			DOUBLE_SPEED_CORE <= 1'b0;
		end
	endtask
	task t_power;
		begin
			apb(1'b1, A_PC, 32'h00000000);
			rst(1'b0);
			rdc("flag warm", A_PC, 32'h00000000, 32'h000000DF);
			apb(1'b1, A_PC, 32'h0000001D);
			rdc("power rw", A_PC, 32'h0000001D, 32'h000000DF);
			repeat (2) @(posedge SYS_CLK);
			chk("sleep", 32'h00000001, {31'h00000000, SLEEP});
			@(posedge SYS_CLK);
			INTERRUPT_EVENT <= 1'b1;
			@(posedge SYS_CLK);
			INTERRUPT_EVENT <= 1'b0;
			repeat (3) @(posedge SYS_CLK);
			chk("sleep wake", 32'h00000000, {31'h00000000, SLEEP});
			apb(1'b1, A_PC, 32'h00000012);
			repeat (3) @(posedge SYS_CLK);
			chk("pdown", 32'h00000001, {31'h00000000, POWER_DOWN});
			rst(1'b0);
			chk("pdown reset", 32'h00000000, {31'h00000000, POWER_DOWN});
			apb(1'b1, A_PC, 32'h00000000);
			rst(1'b1);
			rdc("flag cold", A_PC, 32'h00000010, 32'h000000DF);
			apb(1'b1, A_PC, 32'h00000090);
			apb(1'b1, A_SC, 32'h00000040);
			repeat (3) @(posedge SYS_CLK);
			chk("double", 32'h00000001, {31'h00000000, SERIAL_DOUBLE_RATE});
			apb(1'b1, A_SC, 32'h00000000);
			repeat (3) @(posedge SYS_CLK);
			chk("double m0", 32'h00000000, {31'h00000000, SERIAL_DOUBLE_RATE});
		end
	endtask
	task t_match;
		begin
			apb(1'b1, `IDX_OWN_ADDRESS * 12'h004, 32'h00000056);
			apb(1'b1, `IDX_ADDRESS_MASK * 12'h004, 32'h000000FC);
			frame(8'hA0, 8'h54, 1'b1, 1'b1, 1'b1);
			frame(8'hA0, 8'h57, 1'b1, 1'b1, 1'b1);
			frame(8'hA0, 8'h56, 1'b0, 1'b1, 1'b0);
			frame(8'hA0, 8'h5A, 1'b1, 1'b1, 1'b0);
			frame(8'hA0, 8'hFE, 1'b1, 1'b1, 1'b1);
			frame(8'hE0, 8'h7E, 1'b1, 1'b1, 1'b0);
			frame(8'hE0, 8'h55, 1'b1, 1'b1, 1'b1);
			frame(8'h60, 8'h56, 1'b0, 1'b1, 1'b1);
			frame(8'h60, 8'h56, 1'b0, 1'b0, 1'b0);
			frame(8'h60, 8'h12, 1'b0, 1'b1, 1'b0);
			frame(8'h20, 8'h12, 1'b0, 1'b0, 1'b1);
			frame(8'h80, 8'h12, 1'b0, 1'b1, 1'b1);
			apb(1'b1, `IDX_ADDRESS_MASK * 12'h004, 32'h000000FF);
			frame(8'hA0, 8'h57, 1'b1, 1'b1, 1'b0);
			frame(8'hA0, 8'h56, 1'b1, 1'b1, 1'b1);
			apb(1'b1, A_PC, 32'h00000000);
			apb(1'b1, A_SC, 32'h00000000);
			rdc("err sel off", A_SC, 32'h00000000, 32'h00000080);
			apb(1'b1, A_PC, 32'h00000040);
			rdc("err sel on", A_SC, 32'h00000080, 32'h00000080);
			rdc("status", A_ST, 32'h00000001, 32'h00000001);
		end
	endtask
	// Main sequence after the power-up reset
	initial begin
		repeat (6) @(posedge SYS_CLK);
		RESET <= 1'b0;
		COLD_RESET <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		t_reset;
		t_baud;
		t_power;
		t_match;
		end_sim;
	end
	// Cuts a hang short
	initial begin
		#900000;
		chk("timeout", 32'h00000000, 32'h00000001);
		end_sim;
	end
endmodule // testbench
